//--- pkg/cbcs_pkg.sv
package cbcs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int REF_PERIOD_NS = 4;
  localparam int TSTATE_NS = 16;
  localparam int TICKS_PER_T = TSTATE_NS / REF_PERIOD_NS;
  localparam logic [1:0] PH_PHI1 = 2'h0;
  localparam logic [1:0] PH_GAP1 = 2'h1;
  localparam logic [1:0] PH_PHI2 = 2'h2;
  localparam logic [1:0] PH_GAP2 = 2'h3;
  localparam logic [2:0] T_MIN = 3'h3;
  localparam logic [2:0] T_MAX = 3'h5;
  localparam logic [2:0] M_MAX = 3'h5;

  // ----------------------------------------------------------------
  // Status word bit positions
  // ----------------------------------------------------------------
  localparam int STS_IRQ_ACK = 0;
  localparam int STS_WR_N = 1;
  localparam int STS_STACK = 2;
  localparam int STS_HALT = 3;
  localparam int STS_OUT = 4;
  localparam int STS_FETCH = 5;
  localparam int STS_IN = 6;
  localparam int STS_MEM_READ_FLAG = 7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [2:0] RST_MCYCLE = 3'h0;

  typedef enum logic [3:0] {
    CYC_FETCH = 4'h0, CYC_MEM_RD = 4'h1, CYC_MEM_WR = 4'h2,
    CYC_STK_RD = 4'h3, CYC_STK_WR = 4'h4, CYC_IN_RD = 4'h5,
    CYC_OUT_WR = 4'h6, CYC_IRQ_ACK = 4'h7, CYC_HALT_ACK = 4'h8,
    CYC_IRQ_HALT = 4'h9, CYC_NULL = 4'hA
  } cbcs_cyc_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_T1 = 3'h1, S_T2 = 3'h2, S_WAIT = 3'h3,
    S_T3 = 3'h4, S_T4 = 3'h5, S_T5 = 3'h6, S_HOLD = 3'h7
  } cbcs_state_t;

  // Codes above the eleven known types fall back to the null word.
  function automatic logic [7:0] status_word(input cbcs_cyc_t t);
    case (t)
      CYC_FETCH: status_word = 8'hA2;
      CYC_MEM_RD: status_word = 8'h82;
      CYC_MEM_WR: status_word = 8'h00;
      CYC_STK_RD: status_word = 8'h86;
      CYC_STK_WR: status_word = 8'h04;
      CYC_IN_RD: status_word = 8'h42;
      CYC_OUT_WR: status_word = 8'h10;
      CYC_IRQ_ACK: status_word = 8'h23;
      CYC_HALT_ACK: status_word = 8'h8A;
      CYC_IRQ_HALT: status_word = 8'h2B;
      default: status_word = 8'h02;
    endcase
  endfunction

endpackage

//--- hw/cbcs_phase_gen.sv
`timescale 1ns/1ns
// Splits each T state into phase one, gap, phase two, gap.
module cbcs_phase_gen (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Phase
  output logic [1:0] phase_o,
  output logic phi1_o,
  output logic phi2_o
);

  logic [1:0] next_phase;

  assign next_phase = phase_o + 2'h1;

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  // The two phases are decoded from the next count, so they can never
  // overlap and a gap always follows phase two.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      phase_o <= cbcs_pkg::PH_GAP2;
      phi1_o <= 1'b0;
      phi2_o <= 1'b0;
    end else begin
      phase_o <= next_phase;
      phi1_o <= (next_phase == cbcs_pkg::PH_PHI1);
      phi2_o <= (next_phase == cbcs_pkg::PH_PHI2);
    end
  end

  a_phase_apart: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    !(phi1_o && phi2_o))
    else $error("phases high together");

endmodule

//--- hw/cbcs_sequencer.sv
`timescale 1ns/1ns
module cbcs_sequencer (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Machine cycle request
  input wire logic cyc_valid_i,
  input wire logic [3:0] cyc_type_i,
  input wire logic [2:0] cyc_states_i,
  input wire logic cyc_last_i,
  input wire logic [15:0] cyc_addr_i,
  input wire logic [7:0] cyc_wdata_i,
  output logic cyc_take_o,
  // Control pins
  input wire logic hold_req_i,
  input wire logic ready_i,
  output logic hold_grant_o,
  output logic wait_o,
  output logic sync_o,
  output logic bus_read_strobe_o,
  output logic wr_n_o,
  // Address and data bus
  output logic [15:0] addr_o,
  output logic addr_oe_o,
  input wire logic [7:0] db_i,
  output logic [7:0] db_o,
  output logic db_oe_o,
  // Results and state
  output logic [7:0] rdata_o,
  output logic rdata_valid_o,
  output logic [7:0] opcode_o,
  output logic [2:0] tstate_o,
  output logic [2:0] mcycle_o,
  output logic phi1_o,
  output logic phi2_o
);

  logic [1:0] phase;
  logic at_p2;
  logic at_t_end;
  logic take;
  logic rdy_q;
  logic first_pend;
  logic is_write;
  logic is_read;
  logic float_bus;
  logic [2:0] nstates;
  logic [2:0] next_nstates;
  logic [7:0] cur_sts;
  logic [15:0] cur_addr;
  logic [7:0] cur_wdata;
  cbcs_pkg::cbcs_cyc_t cur_type;
  cbcs_pkg::cbcs_cyc_t next_type;
  cbcs_pkg::cbcs_state_t state;
  cbcs_pkg::cbcs_state_t next_state;
  cbcs_pkg::cbcs_state_t end_state;

  cbcs_phase_gen u_phase (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .phase_o(phase),
    .phi1_o(phi1_o),
    .phi2_o(phi2_o)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  assign at_p2 = (phase == cbcs_pkg::PH_GAP1);
  assign at_t_end = (phase == cbcs_pkg::PH_GAP2);
  assign is_write = !cur_sts[cbcs_pkg::STS_WR_N];
  // Halt acknowledge moves no data, so it never opens the bus for reading.
  assign is_read = cur_sts[cbcs_pkg::STS_WR_N] && (cur_type != cbcs_pkg::CYC_HALT_ACK);
  assign float_bus = (next_state == cbcs_pkg::S_IDLE) || (next_state == cbcs_pkg::S_HOLD);
  assign take = at_t_end && (next_state == cbcs_pkg::S_T1);

  // ----------------------------------------------------------------
  // State sequencing
  // ----------------------------------------------------------------
  always_comb begin
    if (hold_req_i) begin
      end_state = cbcs_pkg::S_HOLD;
    end else if (cyc_valid_i) begin
      end_state = cbcs_pkg::S_T1;
    end else begin
      end_state = cbcs_pkg::S_IDLE;
    end
  end

  always_comb begin
    next_state = state;
    if (at_t_end) begin
      case (state)
        cbcs_pkg::S_IDLE: next_state = end_state;
        cbcs_pkg::S_T1: next_state = cbcs_pkg::S_T2;
        cbcs_pkg::S_T2, cbcs_pkg::S_WAIT: begin
          next_state = rdy_q ? cbcs_pkg::S_T3 : cbcs_pkg::S_WAIT;
        end
        cbcs_pkg::S_T3: begin
          next_state = (nstates > cbcs_pkg::T_MIN) ? cbcs_pkg::S_T4 : end_state;
        end
        cbcs_pkg::S_T4: begin
          next_state = (nstates == cbcs_pkg::T_MAX) ? cbcs_pkg::S_T5 : end_state;
        end
        cbcs_pkg::S_T5: next_state = end_state;
        cbcs_pkg::S_HOLD: next_state = end_state;
        default: next_state = cbcs_pkg::S_IDLE;
      endcase
    end
  end

  // A new cycle starts at the boundary that opens phase one of T1.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= cbcs_pkg::S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Ready is caught during phase one; the wait ends with that T state.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdy_q <= 1'b0;
    end else if (phase == cbcs_pkg::PH_PHI1) begin
      rdy_q <= ready_i;
    end
  end

  // ----------------------------------------------------------------
  // Cycle acceptance
  // ----------------------------------------------------------------
  always_comb begin
    next_type = cbcs_pkg::cbcs_cyc_t'(cyc_type_i);
    if (cyc_type_i > 4'hA) begin
      next_type = cbcs_pkg::CYC_NULL;
    end
    // Only an interrupt acknowledge may stand in for the opcode fetch.
    if (first_pend && (next_type != cbcs_pkg::CYC_IRQ_ACK)
        && (next_type != cbcs_pkg::CYC_IRQ_HALT)) begin
      next_type = cbcs_pkg::CYC_FETCH;
    end
    if (cyc_states_i < cbcs_pkg::T_MIN) begin
      next_nstates = cbcs_pkg::T_MIN;
    end else if (cyc_states_i > cbcs_pkg::T_MAX) begin
      next_nstates = cbcs_pkg::T_MAX;
    end else begin
      next_nstates = cyc_states_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_type <= cbcs_pkg::CYC_NULL;
      cur_sts <= 8'h02;
      nstates <= cbcs_pkg::T_MIN;
      cur_addr <= cbcs_pkg::RST_ADDR;
      cur_wdata <= cbcs_pkg::RST_BYTE;
    end else if (take) begin
      cur_type <= next_type;
      cur_sts <= cbcs_pkg::status_word(next_type);
      nstates <= next_nstates;
      cur_addr <= cyc_addr_i;
      cur_wdata <= cyc_wdata_i;
    end
  end

  // Counts machine cycles of the instruction; the fifth always closes it.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_pend <= 1'b1;
      mcycle_o <= cbcs_pkg::RST_MCYCLE;
    end else if (take) begin
      if (first_pend) begin
        mcycle_o <= 3'h1;
      end else begin
        mcycle_o <= mcycle_o + 3'h1;
      end
      first_pend <= cyc_last_i || (!first_pend && (mcycle_o + 3'h1 == cbcs_pkg::M_MAX));
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cyc_take_o <= 1'b0;
    end else begin
      cyc_take_o <= take;
    end
  end

  // ----------------------------------------------------------------
  // Control pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_o <= 1'b0;
    end else if (at_p2) begin
      sync_o <= (state == cbcs_pkg::S_T1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_o <= 1'b0;
      hold_grant_o <= 1'b0;
      wr_n_o <= 1'b1;
      tstate_o <= cbcs_pkg::S_IDLE;
    end else begin
      wait_o <= (next_state == cbcs_pkg::S_WAIT);
      hold_grant_o <= (next_state == cbcs_pkg::S_HOLD);
      wr_n_o <= !((next_state == cbcs_pkg::S_T3) && is_write);
      tstate_o <= next_state;
    end
  end

  // The strobe opens at phase two of T2 and spans any wait states.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_read_strobe_o <= 1'b0;
    end else if (float_bus) begin
      bus_read_strobe_o <= 1'b0;
    end else if (at_p2) begin
      if (state == cbcs_pkg::S_T2) begin
        bus_read_strobe_o <= is_read;
      end else if (state != cbcs_pkg::S_WAIT) begin
        bus_read_strobe_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address bus
  // ----------------------------------------------------------------
  // The address stays through T4 and T5 as well, so it is still there
  // after T3 when the fetched byte has been taken in.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_o <= cbcs_pkg::RST_ADDR;
      addr_oe_o <= 1'b0;
    end else if (float_bus) begin
      addr_oe_o <= 1'b0;
    end else if (at_p2 && (state == cbcs_pkg::S_T1)) begin
      addr_o <= cur_addr;
      addr_oe_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Data bus
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      db_o <= cbcs_pkg::RST_BYTE;
      db_oe_o <= 1'b0;
    end else if (float_bus || (next_state == cbcs_pkg::S_T4)
                 || (next_state == cbcs_pkg::S_T5)) begin
      db_oe_o <= 1'b0;
    end else if (at_p2) begin
      case (state)
        cbcs_pkg::S_T1: begin
          db_o <= cur_sts;
          db_oe_o <= 1'b1;
        end
        cbcs_pkg::S_T2: begin
          db_o <= cur_wdata;
          db_oe_o <= is_write;
        end
        cbcs_pkg::S_WAIT, cbcs_pkg::S_T3: begin
          db_oe_o <= db_oe_o;
        end
        default: db_oe_o <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  // Data is taken at phase two of T3, after any wait time was spent.
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= cbcs_pkg::RST_BYTE;
      rdata_valid_o <= 1'b0;
      opcode_o <= cbcs_pkg::RST_BYTE;
    end else begin
      rdata_valid_o <= 1'b0;
      if (at_p2 && (state == cbcs_pkg::S_T3) && is_read) begin
        rdata_o <= db_i;
        rdata_valid_o <= 1'b1;
        if (cur_sts[cbcs_pkg::STS_FETCH]) begin
          opcode_o <= db_i;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_sync_width: assert property (
    $rose(sync_o) |-> sync_o[*4] ##1 !sync_o)
    else $error("cycle-start pulse not one T state wide");

  a_sync_in_t1: assert property (
    $rose(sync_o) |-> (tstate_o == cbcs_pkg::S_T1) && (phase == cbcs_pkg::PH_PHI2))
    else $error("cycle-start rose outside phase two of T1");

  a_status_word: assert property (
    $rose(sync_o) |-> db_oe_o && (db_o == cbcs_pkg::status_word(cur_type)))
    else $error("status word missing at cycle start");

  a_status_stable: assert property (
    sync_o && $past(sync_o) |-> $stable(db_o) && db_oe_o)
    else $error("status word moved while cycle-start high");

  a_hold_float: assert property (
    hold_grant_o |-> !db_oe_o && !addr_oe_o)
    else $error("bus driven during hold grant");

  a_wait_stable: assert property (
    wait_o && $past(wait_o) |-> $stable(addr_o) && $stable(db_oe_o) && $stable(db_o))
    else $error("bus changed during wait");

  a_wait_state: assert property (
    wait_o |-> (tstate_o == cbcs_pkg::S_WAIT) && !sync_o)
    else $error("wait output out of step");

  a_no_status_t45: assert property (
    (tstate_o == cbcs_pkg::S_T4) || (tstate_o == cbcs_pkg::S_T5) |-> !db_oe_o)
    else $error("data bus driven in internal state");

  a_first_fetch: assert property (
    $rose(sync_o) && (mcycle_o == 3'h1)
      |-> db_o[cbcs_pkg::STS_FETCH] && !db_o[cbcs_pkg::STS_WR_N] == 1'b0)
    else $error("first machine cycle is not a fetch");

  a_write_only: assert property (
    !wr_n_o |-> !cur_sts[cbcs_pkg::STS_WR_N] && (tstate_o == cbcs_pkg::S_T3))
    else $error("write strobe outside write cycle");

  a_read_float: assert property (
    bus_read_strobe_o |-> !db_oe_o ##[1:300] !bus_read_strobe_o)
    else $error("read strobe while driving the bus");

  c_wait_seen: cover property ($rose(wait_o));
  c_hold_seen: cover property ($rose(hold_grant_o));
  c_five_states: cover property (tstate_o == cbcs_pkg::S_T5);
  c_write_cycle: cover property ($fell(wr_n_o));

endmodule

//--- test/cbcs_bus_partner.sv
`timescale 1ns/1ns
// ------------------------------------------------
// Memory, I/O and status latch beside the sequencer
// ------------------------------------------------
module cbcs_bus_partner (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Sequencer pins
  input wire logic sync_i,
  input wire logic phi1_i,
  input wire logic phi2_i,
  input wire logic strobe_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] db_i,
  input wire logic db_oe_i,
  // Slow device setting and results
  input wire logic [1:0] wait_cnt_i,
  output logic ready_o,
  output logic [7:0] db_o,
  output logic [7:0] sts_o
);
  logic [7:0] last_db;
  logic [1:0] cnt;
  logic sync_q;
  logic phi2_q;

  // A released bus shows the inverse of its last value, so it flips every clock and the last byte returns on every other clock.
  assign db_o = strobe_i ? (addr_i[7:0] ^ addr_i[15:8] ^ 8'h5A) : ~last_db;
  assign ready_o = (cnt == 2'h0);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      last_db <= 8'h00;
      sync_q <= 1'b0;
      phi2_q <= 1'b0;
      cnt <= 2'h0;
      sts_o <= 8'h00;
    end else begin
      last_db <= db_o;
      sync_q <= sync_i;
      phi2_q <= phi2_i;
      // One phase-two per stalled state, so the count equals the wait states asked.
      if (sync_i && !sync_q) begin
        cnt <= wait_cnt_i;
      end else if (phi2_i && !phi2_q && !sync_i && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end
      if (sync_i && phi1_i) begin
        sts_o <= db_oe_i ? db_i : 8'h00;
      end
    end
  end
endmodule

//--- test/cpu_bus_cycle_status_tb.sv
`timescale 1ns/1ns
module cpu_bus_cycle_status_tb;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic cyc_valid_i = 1'b0;
  logic [3:0] cyc_type_i = 4'h0;
  logic [2:0] cyc_states_i = 3'h3;
  logic cyc_last_i = 1'b0;
  logic [15:0] cyc_addr_i = 16'h0000;
  logic [7:0] cyc_wdata_i = 8'h00;
  logic hold_req_i = 1'b0;
  logic [1:0] wait_cnt = 2'h0;
  logic ready, cyc_take_o, hold_grant_o, wait_o, sync_o, bus_read_strobe_o, wr_n_o;
  logic addr_oe_o, db_oe_o, rdata_valid_o, phi1_o, phi2_o;
  logic [15:0] addr_o;
  logic [7:0] db_i, db_o, rdata_o, opcode_o, sts;
  logic [2:0] tstate_o, mcycle_o;
  int errors = 0;
  int tests_run = 0;
  int i, k, nc;
  logic [3:0] ty;
  localparam logic [7:0] STS_TAB [0:10] = '{8'hA2, 8'h82, 8'h00, 8'h86, 8'h04, 8'h42,
    8'h10, 8'h23, 8'h8A, 8'h2B, 8'h02};

  always #2 ref_clk_i = ~ref_clk_i;

  cbcs_sequencer cbcs_sequencer_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .cyc_valid_i(cyc_valid_i), .cyc_type_i(cyc_type_i), .cyc_states_i(cyc_states_i),
    .cyc_last_i(cyc_last_i), .cyc_addr_i(cyc_addr_i), .cyc_wdata_i(cyc_wdata_i),
    .cyc_take_o(cyc_take_o), .hold_req_i(hold_req_i), .ready_i(ready),
    .hold_grant_o(hold_grant_o), .wait_o(wait_o), .sync_o(sync_o),
    .bus_read_strobe_o(bus_read_strobe_o), .wr_n_o(wr_n_o), .addr_o(addr_o),
    .addr_oe_o(addr_oe_o), .db_i(db_i), .db_o(db_o), .db_oe_o(db_oe_o),
    .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .opcode_o(opcode_o),
    .tstate_o(tstate_o), .mcycle_o(mcycle_o), .phi1_o(phi1_o), .phi2_o(phi2_o));

  cbcs_bus_partner cbcs_bus_partner_inst (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .sync_i(sync_o), .phi1_i(phi1_o), .phi2_i(phi2_o), .strobe_i(bus_read_strobe_o),
    .addr_i(addr_o), .db_i(db_o), .db_oe_i(db_oe_o), .wait_cnt_i(wait_cnt),
    .ready_o(ready), .db_o(db_i), .sts_o(sts));

  function automatic logic [7:0] mem(input logic [15:0] a);
    mem = a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic run_cyc(input logic [3:0] t, input logic [2:0] st, input logic lst,
                         input int nw, input int mc);
    logic [15:0] a;
    logic [7:0] wd, es;
    logic wr, rd, ps, wlow;
    int n, waits, t45, est, nrd;
    a = 16'($urandom);
    wd = 8'($urandom);
    es = (t > 4'hA) ? 8'h02 : STS_TAB[t];
    wr = !es[1];
    rd = !wr && es != 8'h8A;
    est = (st < 3'h3) ? 3 : ((st > 3'h5) ? 5 : int'(st));
    @(posedge ref_clk_i);
    wait_cnt <= 2'(nw);
    cyc_valid_i <= 1'b1;
    cyc_type_i <= t;
    cyc_states_i <= st;
    cyc_last_i <= lst;
    cyc_addr_i <= a;
    cyc_wdata_i <= wd;
    n = 0;
    while (cyc_take_o !== 1'b1 && n < 100) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(cyc_take_o, 1'b1);
    chk({phi1_o, tstate_o}, 4'h9);
    @(posedge ref_clk_i);
    cyc_valid_i <= 1'b0;
    n = 0;
    waits = 0;
    nrd = 0;
    t45 = 0;
    ps = 1'b0;
    wlow = 1'b0;
    while (tstate_o !== 3'h0 && n < 400) begin
      @(negedge ref_clk_i);
      n++;
      chk(wait_o, tstate_o == 3'h3);
      chk(phi1_o && phi2_o, 1'b0);
      if (sync_o && !ps) begin
        chk(phi2_o, 1'b1);
        chk(addr_o, a);
        chk(addr_oe_o, 1'b1);
        chk(db_o, es);
        chk(db_oe_o, 1'b1);
        chk(mcycle_o, 16'(mc));
      end
      if (!sync_o && ps) begin
        chk(phi2_o, 1'b1);
        chk(db_oe_o, wr);
        chk(bus_read_strobe_o, rd);
        chk(sts, es);
      end
      if (tstate_o == 3'h3) begin
        waits++;
        chk(addr_o, a);
      end
      if (tstate_o > 3'h4 && tstate_o < 3'h7) begin
        t45++;
        chk(db_oe_o, 1'b0);
      end
      if (rdata_valid_o) begin
        nrd++;
        chk(rdata_o, mem(a));
      end
      if (!wr_n_o) begin
        wlow = 1'b1;
        chk(db_o, wd);
      end
      ps = sync_o;
    end
    chk(n < 400, 1'b1);
    chk(16'(waits), 16'(nw * cbcs_pkg::TICKS_PER_T));
    chk(16'(t45), 16'((est - 3) * cbcs_pkg::TICKS_PER_T));
    chk(16'(nrd), 16'(rd));
    chk(wlow, wr);
    if (es[5]) begin
      chk(opcode_o, mem(a));
    end
  endtask

  task automatic hold_test;
    int n;
    @(posedge ref_clk_i);
    hold_req_i <= 1'b1;
    cyc_valid_i <= 1'b1;
    n = 0;
    while (hold_grant_o !== 1'b1 && n < 40) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(hold_grant_o, 1'b1);
    chk({addr_oe_o, db_oe_o}, 2'h0);
    repeat (24) begin
      @(negedge ref_clk_i);
      chk(cyc_take_o, 1'b0);
    end
    @(posedge ref_clk_i);
    hold_req_i <= 1'b0;
    cyc_valid_i <= 1'b0;
  endtask

  initial begin
    #80000;
    errors++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    void'($urandom(40));
    repeat (16) @(posedge ref_clk_i);
    chk({wr_n_o, sync_o, hold_grant_o, tstate_o}, 6'h20);
    rst_b_i <= 1'b1;
    // Cycle codes 1 to 10 each follow a fetch, with wait counts 0 to 2 and state counts 3 to 5.
    for (i = 1; i < 11; i++) begin
      run_cyc(4'h0, 3'h3, 1'b0, 0, 1);
      run_cyc(4'(i), 3'(3 + i % 3), 1'b1, i % 3, 2);
    end
    hold_test();
    for (i = 0; i < 12; i++) begin
      nc = $urandom_range(5, 1);
      for (k = 0; k < nc; k++) begin
        ty = (i == 3) ? 4'h7 : ((i == 8) ? 4'h9 : 4'h0);
        if (k > 0) begin
          ty = (i == 5) ? 4'hF : 4'($urandom_range(10, 1));
        end
        run_cyc(ty, 3'($urandom_range(6, 2)), k == nc - 1, $urandom_range(2), k + 1);
      end
    end
    close_out();
  end
endmodule
